// [rcd_pkg.sv]
// rcd_pkg: shared constants and types of the calendar register block
package rcd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_WEEKDAY = 8'h04;
    localparam logic [7:0] OFS_DATE = 8'h05;
    localparam logic [7:0] OFS_MONTH = 8'h06;
    localparam logic [7:0] OFS_YEAR = 8'h07;

    // reset values
    localparam logic [7:0] RST_WEEKDAY = 8'h01;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h01;

    // weekday and status field positions
    localparam int POS_OSC_RUN = 5;
    localparam int POS_PWR_LOSS = 4;
    localparam int POS_VBAT_EN = 3;
    // month field position
    localparam int POS_LEAP = 5;

    // writable masks; other positions are unimplemented but weekday bits 5-3 and month bit 5
    localparam logic [7:0] MSK_WEEKDAY = 8'h07;
    localparam logic [7:0] MSK_DATE = 8'h3F;
    localparam logic [7:0] MSK_MONTH = 8'h1F;
    localparam logic [7:0] MSK_YEAR = 8'hFF;

    // bcd values used by the calendar step and the weekday counter
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [3:0] BCD_ONE = 4'h1;
    localparam logic [2:0] WEEKDAY_FIRST = 3'h1;
    localparam logic [2:0] WEEKDAY_LAST = 3'h7;
    localparam logic [7:0] BCD_FIRST = 8'h01;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_OCT = 8'h10;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [7:0] MON_DEC = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] YEAR_FIRST = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rcd_req_t;

    typedef struct packed {
        logic [1:0] date_tens_digit;
        logic [3:0] date_units_digit;
        logic month_tens_digit;
        logic [3:0] month_units_digit;
        logic [3:0] year_tens_digit;
        logic [3:0] year_units_digit;
    } rcd_cal_t;

endpackage

// [rcd_cal_step.sv]
// rcd_cal_step: next calendar date after a day rollover, plus leap detect
`timescale 1ns/1ps
`default_nettype none
module rcd_cal_step (
    input wire rcd_pkg::rcd_cal_t cur,
    output var rcd_pkg::rcd_cal_t nxt,
    output logic leap
);
    import rcd_pkg::*;

    wire [7:0] date_b = {2'b00, cur.date_tens_digit, cur.date_units_digit};
    wire [7:0] mon_b = {3'b000, cur.month_tens_digit, cur.month_units_digit};
    wire [7:0] year_b = {cur.year_tens_digit, cur.year_units_digit};

    // two-digit year divisible by four, worked in bcd
    wire tens_odd = cur.year_tens_digit[0];
    wire units_mod4 = (cur.year_units_digit[1:0] == 2'b00);
    wire units_mod2 = (cur.year_units_digit[1:0] == 2'b10);
    assign leap = tens_odd ? units_mod2 : units_mod4;

    wire is_short = (mon_b == MON_APR) || (mon_b == MON_JUN) ||
                    (mon_b == MON_SEP) || (mon_b == MON_NOV);
    wire [7:0] last_day = (mon_b == MON_FEB) ? (leap ? DAYS_29 : DAYS_28) :
                          (is_short ? DAYS_30 : DAYS_31);
    wire month_end = (date_b >= last_day);
    wire year_end = (mon_b == MON_DEC);

    wire [7:0] date_inc = (cur.date_units_digit == BCD_NINE) ?
        {2'b00, cur.date_tens_digit + 2'b01, BCD_ZERO} : date_b + 8'h01;
    wire [7:0] mon_inc = (mon_b == MON_SEP) ? MON_OCT : mon_b + 8'h01;
    wire [7:0] year_inc = (year_b == YEAR_LAST) ? YEAR_FIRST :
        (cur.year_units_digit == BCD_NINE) ?
        {cur.year_tens_digit + BCD_ONE, BCD_ZERO} : year_b + 8'h01;

    wire [7:0] date_n = month_end ? BCD_FIRST : date_inc;
    wire [7:0] mon_n = !month_end ? mon_b : (year_end ? BCD_FIRST : mon_inc);
    wire [7:0] year_n = (month_end && year_end) ? year_inc : year_b;

    assign nxt.date_tens_digit = date_n[5:4];
    assign nxt.date_units_digit = date_n[3:0];
    assign nxt.month_tens_digit = mon_n[4];
    assign nxt.month_units_digit = mon_n[3:0];
    assign nxt.year_tens_digit = year_n[7:4];
    assign nxt.year_units_digit = year_n[3:0];
endmodule
`default_nettype wire

// [rcd_calendar.sv]
// rcd_calendar: weekday/status, date, month and year registers of the clock
//
// Functional notes
// - date kept as bcd: tens digit bits 5-4 (0-3), units bits 3-0 (0-9)
// - month tens digit is one bit at position 4, value 0 or 1
// - month units digit is a 4-bit bcd field in bits 3-0, 0 to 9
// - year kept as bcd: tens bits 7-4, units bits 3-0, each 0 to 9
// - month bit 5 is a read-only leap-year flag for the current year
// - unimplemented bits ignore writes and read as zero
// - power-loss flag cleared only by writing zero; only hardware sets it
// - while power-loss flag set, no new timestamp may be logged
// - oscillator go bit in seconds register starts (1) or stops (0) timekeeping
`timescale 1ns/1ps
`default_nettype none
module rcd_calendar (
    input wire logic mclk,
    input wire logic rst,
    input wire rcd_pkg::rcd_req_t req,
    input wire logic day_rollover,
    input wire logic osc_go_bit,
    input wire logic osc_clock_present,
    input wire logic power_fail_event,
    output logic [rcd_pkg::DATA_W-1:0] rdata,
    output logic rvalid,
    output logic backup_supply_enable,
    output logic timestamp_log_allow,
    output logic osc_running_flag
);
    import rcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    rcd_cal_t cal_q, cal_d;
    logic [2:0] weekday_counter_q, weekday_counter_d;
    logic power_loss_flag_q, power_loss_flag_d;
    logic vbat_en_q, vbat_en_d;
    logic osc_run_q;
    logic [1:0] osc_sync_q;
    logic [1:0] pfail_sync_q;
    logic pfail_prev_q;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic ts_allow_q;

    rcd_cal_t cal_next;
    logic leap_year_flag;

    rcd_cal_step u_step (
        .cur(cal_q),
        .nxt(cal_next),
        .leap(leap_year_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire sel_weekday = (req.addr == OFS_WEEKDAY);
    wire sel_date = (req.addr == OFS_DATE);
    wire sel_month = (req.addr == OFS_MONTH);
    wire sel_year = (req.addr == OFS_YEAR);

    wire wr_weekday = req.wr && sel_weekday;
    wire wr_date = req.wr && sel_date;
    wire wr_month = req.wr && sel_month;
    wire wr_year = req.wr && sel_year;

    // only writable bits are taken from the bus
    wire [DATA_W-1:0] wd_date = req.wdata & MSK_DATE;
    wire [DATA_W-1:0] wd_month = req.wdata & MSK_MONTH;
    wire [DATA_W-1:0] wd_year = req.wdata & MSK_YEAR;
    wire [DATA_W-1:0] wd_weekday = req.wdata & MSK_WEEKDAY;

    ////////////////////////////////////////////////////////////////////////
    // read image

    wire [DATA_W-1:0] img_weekday = {2'b00, osc_run_q, power_loss_flag_q, vbat_en_q,
                                   weekday_counter_q};
    wire [DATA_W-1:0] img_date = {2'b00, cal_q.date_tens_digit,
                                  cal_q.date_units_digit};
    wire [DATA_W-1:0] img_month = {2'b00, leap_year_flag, cal_q.month_tens_digit,
                                   cal_q.month_units_digit};
    wire [DATA_W-1:0] img_year = {cal_q.year_tens_digit,
                                  cal_q.year_units_digit};

    always_comb begin
        if (sel_weekday) begin
            rdata_d = img_weekday;
        end else if (sel_date) begin
            rdata_d = img_date;
        end else if (sel_month) begin
            rdata_d = img_month;
        end else if (sel_year) begin
            rdata_d = img_year;
        end else begin
            rdata_d = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calendar counters: a write to a register wins over the rollover

    always_comb begin
        cal_d = cal_q;
        if (day_rollover && osc_run_q) begin
            cal_d = cal_next;
        end
        if (wr_date) begin
            cal_d.date_tens_digit = wd_date[5:4];
            cal_d.date_units_digit = wd_date[3:0];
        end
        if (wr_month) begin
            cal_d.month_tens_digit = wd_month[4];
            cal_d.month_units_digit = wd_month[3:0];
        end
        if (wr_year) begin
            cal_d.year_tens_digit = wd_year[7:4];
            cal_d.year_units_digit = wd_year[3:0];
        end
    end

    // a written zero is out of range and steps to the first day on rollover
    wire [2:0] weekday_inc = (weekday_counter_q >= WEEKDAY_LAST) ? WEEKDAY_FIRST :
                             weekday_counter_q + 3'h1;

    always_comb begin
        weekday_counter_d = weekday_counter_q;
        vbat_en_d = vbat_en_q;
        if (day_rollover && osc_run_q) begin
            weekday_counter_d = weekday_inc;
        end
        if (wr_weekday) begin
            weekday_counter_d = wd_weekday[2:0];
            vbat_en_d = req.wdata[POS_VBAT_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-loss flag: hardware set wins over a software clear

    // the failure edge is taken after the synchroniser; a clear written in the
    // same cycle as a new failure loses, so no failure goes unrecorded
    wire pfail_rise = pfail_sync_q[1] && !pfail_prev_q;
    wire pwr_clear = wr_weekday && !req.wdata[POS_PWR_LOSS];

    always_comb begin
        power_loss_flag_d = power_loss_flag_q;
        if (pwr_clear) begin
            power_loss_flag_d = 1'b0;
        end
        if (pfail_rise) begin
            power_loss_flag_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flops

    always_ff @(posedge mclk) begin
        if (rst) begin
            cal_q <= rcd_cal_t'({RST_DATE[5:0], RST_MONTH[4:0], RST_YEAR});
        end else begin
            cal_q <= cal_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            weekday_counter_q <= RST_WEEKDAY[2:0];
            vbat_en_q <= RST_WEEKDAY[POS_VBAT_EN];
            power_loss_flag_q <= RST_WEEKDAY[POS_PWR_LOSS];
        end else begin
            weekday_counter_q <= weekday_counter_d;
            vbat_en_q <= vbat_en_d;
            power_loss_flag_q <= power_loss_flag_d;
        end
    end

    // oscillator sense and power-fail event arrive from outside the domain
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_sync_q <= 2'b00;
            pfail_sync_q <= 2'b00;
            pfail_prev_q <= 1'b0;
        end else begin
            osc_sync_q <= {osc_sync_q[0], osc_clock_present};
            pfail_sync_q <= {pfail_sync_q[0], power_fail_event};
            pfail_prev_q <= pfail_sync_q[1];
        end
    end

    // log permit follows the next flag value so it changes with the flag itself
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_run_q <= RST_WEEKDAY[POS_OSC_RUN];
            ts_allow_q <= 1'b0;
        end else begin
            osc_run_q <= osc_go_bit && osc_sync_q[1];
            ts_allow_q <= !power_loss_flag_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= req.rd ? rdata_d : '0;
            rvalid_q <= req.rd;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign backup_supply_enable = vbat_en_q;
    assign timestamp_log_allow = ts_allow_q;
    assign osc_running_flag = osc_run_q;
endmodule
`default_nettype wire

// [rcd_cal_monitor.sv]
// rcd_cal_monitor: port-level checks of the calendar register block
`timescale 1ns/1ps
`default_nettype none
module rcd_cal_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire rcd_pkg::rcd_req_t req,
    input wire logic day_rollover,
    input wire logic osc_go_bit,
    input wire logic osc_clock_present,
    input wire logic power_fail_event,
    input wire logic [rcd_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic backup_supply_enable,
    input wire logic timestamp_log_allow,
    input wire logic osc_running_flag
);
    import rcd_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_rd_answer; req.rd |=> rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_idle; !req.rd |=> !rvalid; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read answer without request");
    property p_date; rvalid && $past(req.addr) == OFS_DATE |->
        rdata[7:6] == 2'h0 && rdata[5:4] <= 2'h3 && rdata[3:0] <= BCD_NINE; endproperty
    a_date: assert property (p_date) else $error("date field out of range");
    property p_month; rvalid && $past(req.addr) == OFS_MONTH |->
        rdata[7:6] == 2'h0 && rdata[3:0] <= BCD_NINE; endproperty
    a_month: assert property (p_month) else $error("month field out of range");
    property p_year; rvalid && $past(req.addr) == OFS_YEAR |->
        rdata[7:4] <= BCD_NINE && rdata[3:0] <= BCD_NINE; endproperty
    a_year: assert property (p_year) else $error("year field out of range");
    property p_weekday; rvalid && $past(req.addr) == OFS_WEEKDAY |-> rdata[7:6] == 2'h0 &&
        rdata[5] == $past(osc_running_flag) && rdata[3] == $past(backup_supply_enable);
    endproperty
    a_weekday: assert property (p_weekday) else $error("weekday status mismatch");
    property p_osc_off; !osc_go_bit |=> !osc_running_flag; endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc flag high while off");
    property p_osc_pin; !osc_clock_present ##1 !osc_clock_present ##1 !osc_clock_present
        |=> !osc_running_flag; endproperty
    a_osc_pin: assert property (p_osc_pin) else $error("osc flag high without clock");
    property p_pf_set; $rose(power_fail_event) |-> ##[1:6] !timestamp_log_allow; endproperty
    a_pf_set: assert property (p_pf_set) else $error("power loss not flagged");
    property p_pf_hw; $fell(timestamp_log_allow) |-> $past(power_fail_event, 3); endproperty
    a_pf_hw: assert property (p_pf_hw) else $error("power loss set without event");
endmodule
`default_nettype wire

// [rcd_host_model.sv]
// rcd_host_model: host side issuing register requests and the start bit
`timescale 1ns/1ps
`default_nettype none
module rcd_host_model (
    input wire logic mclk,
    output var rcd_pkg::rcd_req_t req,
    output logic osc_go_bit,
    input wire logic [rcd_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid
);
    import rcd_pkg::*;
    initial begin
        req = '0;
        osc_go_bit = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // released address and data lines are inverted so a stale address is never reused
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge mclk);
        #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = rvalid ? rdata : 8'hXX;
    endtask
    task automatic go(input logic v);
        @(posedge mclk);
        #1 osc_go_bit = v;
    endtask
endmodule
`default_nettype wire

// [rcd_calendar_test.sv]
// rcd_calendar_test: self-checking bench of the calendar register block
`timescale 1ns/1ps
`default_nettype none
module rcd_calendar_test;
    import rcd_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic day_rollover = 1'b0;
    logic osc_clock_present = 1'b0;
    logic power_fail_event = 1'b0;
    logic osc_go_bit, rvalid, backup_supply_enable, timestamp_log_allow, osc_running_flag;
    rcd_req_t req;
    logic [7:0] rdata;
    int miscompares = 0;
    int checked = 0;
    always #25 mclk = ~mclk;
    rcd_calendar i_dut (.mclk(mclk), .rst(rst), .req(req), .day_rollover(day_rollover),
        .osc_go_bit(osc_go_bit), .osc_clock_present(osc_clock_present),
        .power_fail_event(power_fail_event), .rdata(rdata), .rvalid(rvalid),
        .backup_supply_enable(backup_supply_enable),
        .timestamp_log_allow(timestamp_log_allow), .osc_running_flag(osc_running_flag));
    rcd_host_model i_host (.mclk(mclk), .req(req), .osc_go_bit(osc_go_bit), .rdata(rdata),
        .rvalid(rvalid));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, e);
        logic [7:0] q;
        i_host.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic t_reset_vals();
        rd_chk(OFS_WEEKDAY, RST_WEEKDAY);
        rd_chk(OFS_DATE, RST_DATE);
        rd_chk(OFS_MONTH, RST_MONTH);
        rd_chk(OFS_YEAR, RST_YEAR);
        rd_chk(8'h08, 8'h00);
    endtask
    task automatic t_fields();
        wr(OFS_DATE, 8'hF9);
        rd_chk(OFS_DATE, 8'h39);
        wr(OFS_MONTH, 8'hF2);
        rd_chk(OFS_MONTH, 8'h12);
        wr(OFS_YEAR, 8'h24);
        rd_chk(OFS_MONTH, 8'h32);
        wr(OFS_WEEKDAY, 8'hFF);
        rd_chk(OFS_WEEKDAY, 8'h0F);
        chk({7'h0, backup_supply_enable}, 8'h01);
    endtask
    task automatic t_roll(input logic [7:0] dt, mo, yr, wk, edt, emo, eyr, ewk);
        wr(OFS_DATE, dt);
        wr(OFS_MONTH, mo);
        wr(OFS_YEAR, yr);
        wr(OFS_WEEKDAY, wk);
        @(posedge mclk);
        #1 day_rollover = 1'b1;
        @(posedge mclk);
        #1 day_rollover = 1'b0;
        rd_chk(OFS_DATE, edt);
        rd_chk(OFS_MONTH, emo);
        rd_chk(OFS_YEAR, eyr);
        rd_chk(OFS_WEEKDAY, ewk);
    endtask
    task automatic t_osc();
        i_host.go(1'b1);
        osc_clock_present = 1'b1;
        repeat (5) @(posedge mclk);
        #1 chk({7'h0, osc_running_flag}, 8'h01);
        t_roll(DAYS_28, MON_FEB, 8'h23, 8'h07, BCD_FIRST, 8'h03, 8'h23, 8'h21);
        t_roll(DAYS_28, MON_FEB, 8'h24, 8'h06, DAYS_29, 8'h22, 8'h24, 8'h27);
        t_roll(DAYS_31, MON_DEC, YEAR_LAST, 8'h03, BCD_FIRST, 8'h21, YEAR_FIRST, 8'h24);
        i_host.go(1'b0);
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, osc_running_flag}, 8'h00);
        t_roll(8'h15, 8'h05, 8'h24, 8'h02, 8'h15, 8'h25, 8'h24, 8'h02);
        i_host.go(1'b1);
        osc_clock_present = 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk({7'h0, osc_running_flag}, 8'h00);
    endtask
    task automatic t_power();
        power_fail_event = 1'b1;
        repeat (6) @(posedge mclk);
        #1 power_fail_event = 1'b0;
        chk({7'h0, timestamp_log_allow}, 8'h00);
        wr(OFS_WEEKDAY, 8'h15);
        rd_chk(OFS_WEEKDAY, 8'h15);
        wr(OFS_WEEKDAY, 8'h05);
        rd_chk(OFS_WEEKDAY, 8'h05);
        chk({7'h0, timestamp_log_allow}, 8'h01);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        t_reset_vals();
        t_fields();
        t_osc();
        t_power();
        complete_run();
    end
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end
endmodule
bind rcd_calendar rcd_cal_monitor i_mon (.mclk(mclk), .rst(rst), .req(req),
    .day_rollover(day_rollover), .osc_go_bit(osc_go_bit),
    .osc_clock_present(osc_clock_present), .power_fail_event(power_fail_event),
    .rdata(rdata), .rvalid(rvalid), .backup_supply_enable(backup_supply_enable),
    .timestamp_log_allow(timestamp_log_allow), .osc_running_flag(osc_running_flag));
`default_nettype wire
